// File: verilog/ffe_regs.sv
/*
 * Floating-point feature and enable register bank: the read-only second
 * feature register and the exception/enable register, reached by core
 * coprocessor move transfers.
 * Assumes the core presents one transfer at most per cycle, on mclk, and that
 * the undefined-instruction event inputs are single-cycle pulses.
 */
// Functional notes
// RULE_01: Feature register top nibble reports fused multiply-accumulate support as one.
// RULE_02: Feature register bits 27..24 report scalar half precision support as one.
// RULE_03: Feature register bits 23..8, four vector capability nibbles, read zero.
// RULE_04: Feature register bits 7..4 report default NaN support as one.
// RULE_05: Feature register bits 3..0 report full denormal arithmetic support as one.
// RULE_06: Exception register bit 31 and bits 28..0 read zero, writes ignored.
// RULE_07: Exception register bit 30 is the global unit enable, one enables.
// RULE_08: Reset clears the global unit enable, unit starts disabled.
// RULE_09: A vector-operation bounce sets exception register bit 29.
// RULE_10: Any other undefined-instruction exception clears bit 29.
// RULE_11: Exception register needs privileged mode and both coprocessor access enables.
// RULE_12: In non-secure state both non-secure access bits must also be set.
// RULE_13: Reads use the coprocessor-to-core move, writes the core-to-coprocessor move.
// RULE_14: Feature register reads additionally need the global unit enable set.
// RULE_15: Feature register is read-only constant; writes do nothing.
`timescale 1ns/1ns
`default_nettype none

module ffe_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Coprocessor transfer request
    input wire logic xfer_valid,
    input wire logic xfer_write,
    input wire logic xfer_sel,
    input wire logic [31:0] xfer_wdata,
    // Core privilege and access state
    input wire logic priv_mode,
    input wire logic nonsecure,
    input wire logic coproc_access_ctrl_fp_coproc_single,
    input wire logic coproc_access_ctrl_fp_coproc_double,
    input wire logic nonsecure_access_ctrl_fp_coproc_single,
    input wire logic nonsecure_access_ctrl_fp_coproc_double,
    // Undefined-instruction events
    input wire logic vector_bounce,
    input wire logic undef_other,
    // Transfer answer
    output logic xfer_done,
    output logic xfer_undef,
    output logic [31:0] xfer_rdata,
    // Unit state
    output logic fp_enable,
    output logic vector_bounce_flag
);

    // ==========================================================================
    // State and access verdicts
    // ==========================================================================
    ffe_pkg::ffe_state_t state_reg;
    ffe_pkg::ffe_state_t state_next;
    logic exc_ok;
    logic feat_ok;
    logic sel_ok;

    // Exception register image as software reads it
    function automatic logic [31:0] ffe_exc_image(input logic enable, input logic bounce);
        ffe_exc_image = 32'h0000_0000; // Async bit and low bits always zero [RULE_06]
        ffe_exc_image[ffe_pkg::ENABLE_BIT] = enable;
        ffe_exc_image[ffe_pkg::BOUNCE_BIT] = bounce;
    endfunction

    ffe_access_gate u_gate (
        .priv_mode(priv_mode),
        .nonsecure(nonsecure),
        .coproc_access_ctrl_fp_coproc_single(coproc_access_ctrl_fp_coproc_single),
        .coproc_access_ctrl_fp_coproc_double(coproc_access_ctrl_fp_coproc_double),
        .nonsecure_access_ctrl_fp_coproc_single(nonsecure_access_ctrl_fp_coproc_single),
        .nonsecure_access_ctrl_fp_coproc_double(nonsecure_access_ctrl_fp_coproc_double),
        .unit_enable(state_reg.enable),
        .exc_ok(exc_ok),
        .feat_ok(feat_ok)
    );

    // Verdict for whichever register the transfer names
    assign sel_ok = (xfer_sel == ffe_pkg::SEL_FEAT) ? feat_ok : exc_ok;

    // ==========================================================================
    // Next state
    // ==========================================================================
    // Transfer handling first, then exception events so a bounce wins last
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.undef = 1'b0;
        if (xfer_valid) begin
            if (!sel_ok) begin
                // Refused transfer raises an undefined instruction [RULE_11] [RULE_12] [RULE_14]
                state_next.undef = 1'b1;
                state_next.rdata = ffe_pkg::RDATA_RST;
            end else begin
                state_next.done = 1'b1;
                if (xfer_sel == ffe_pkg::SEL_FEAT) begin
                    // Constant image; a write leaves everything untouched [RULE_15]
                    if (!xfer_write) begin
                        // Low nibbles carry the NaN and denormal fields [RULE_04] [RULE_05]
                        state_next.rdata = ffe_pkg::FEAT_SECOND_VALUE; // [RULE_01] [RULE_02] [RULE_03]
                    end
                end else if (xfer_write) begin
                    // Core-to-coprocessor move: only bits 30 and 29 store [RULE_13] [RULE_06]
                    state_next.enable = xfer_wdata[ffe_pkg::ENABLE_BIT]; // [RULE_07]
                    state_next.bounce = xfer_wdata[ffe_pkg::BOUNCE_BIT];
                end else begin
                    // Coprocessor-to-core move [RULE_13]
                    state_next.rdata = ffe_exc_image(state_reg.enable, state_reg.bounce);
                end
            end
        end
        // Our own refusal counts as an undefined instruction too
        if (undef_other || (xfer_valid && !sel_ok)) begin
            state_next.bounce = 1'b0; // [RULE_10]
        end
        // Setting wins over any clear in the same cycle
        if (vector_bounce) begin
            state_next.bounce = 1'b1; // [RULE_09]
        end
    end

    // ==========================================================================
    // State register
    // ==========================================================================
    // Reset clears the enable, bounce flag, answer data and handshake bits; feature data is wired
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg.enable <= ffe_pkg::ENABLE_RST; // [RULE_08]
            state_reg.bounce <= ffe_pkg::BOUNCE_RST;
            state_reg.rdata <= ffe_pkg::RDATA_RST;
            state_reg.done <= 1'b0;
            state_reg.undef <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    assign xfer_done = state_reg.done;
    assign xfer_undef = state_reg.undef;
    assign xfer_rdata = state_reg.rdata;
    assign fp_enable = state_reg.enable; // [RULE_07]
    assign vector_bounce_flag = state_reg.bounce;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic feat_read_ok;
    logic exc_read_ok;
    logic exc_write_ok;
    assign feat_read_ok = xfer_valid && !xfer_write && xfer_sel == ffe_pkg::SEL_FEAT && feat_ok;
    assign exc_read_ok = xfer_valid && !xfer_write && xfer_sel == ffe_pkg::SEL_EXC && exc_ok;
    assign exc_write_ok = xfer_valid && xfer_write && xfer_sel == ffe_pkg::SEL_EXC && exc_ok;

    a_fmac_field: assert property (feat_read_ok |=> xfer_done && xfer_rdata[31:28] == 4'h1) // [RULE_01]
        else $error("fused mac field wrong");
    a_shalf_field: assert property (feat_read_ok |=> xfer_rdata[27:24] == 4'h1) // [RULE_02]
        else $error("scalar half field wrong");
    a_vector_fields: assert property (feat_read_ok |=> xfer_rdata[23:8] == 16'h0000) // [RULE_03]
        else $error("vector fields not zero");
    a_dnan_field: assert property (feat_read_ok |=> xfer_rdata[7:4] == 4'h1) // [RULE_04]
        else $error("default nan field wrong");
    a_denorm_field: assert property (feat_read_ok |=> xfer_rdata[3:0] == 4'h1) // [RULE_05]
        else $error("denormal field wrong");
    a_exc_zero_bits: assert property (exc_read_ok |=> xfer_done && !xfer_rdata[31] // [RULE_06]
                                      && xfer_rdata[28:0] == 29'h0)
        else $error("exception reserved bits not zero");
    a_enable_write: assert property (exc_write_ok |=> fp_enable == $past(xfer_wdata[30])) // [RULE_07]
        else $error("enable bit not written");
    a_enable_reset: assert property ($past(rst) |-> !fp_enable) // [RULE_08]
        else $error("enable not cleared by reset");
    a_bounce_set: assert property (vector_bounce |=> vector_bounce_flag) // [RULE_09]
        else $error("bounce flag not set");
    a_bounce_clear: assert property (undef_other && !vector_bounce |=> !vector_bounce_flag) // [RULE_10]
        else $error("bounce flag not cleared");
    a_priv_refuse: assert property (xfer_valid && !priv_mode |=> xfer_undef && !xfer_done) // [RULE_11]
        else $error("unprivileged access accepted");
    a_ns_refuse: assert property (xfer_valid && nonsecure && !nonsecure_access_ctrl_fp_coproc_single |=> xfer_undef) // [RULE_12]
        else $error("non-secure access accepted");
    a_read_answer: assert property (exc_read_ok |=> xfer_rdata[30] == $past(fp_enable)) // [RULE_13]
        else $error("read answer does not show enable");
    a_feat_needs_en: assert property (xfer_valid && xfer_sel == ffe_pkg::SEL_FEAT && !fp_enable // [RULE_14]
                                      |=> xfer_undef)
        else $error("feature read with unit disabled");
    // Only a permitted write is inert; a refused one zeroes the answer on purpose
    a_feat_write_inert: assert property (xfer_valid && xfer_write && feat_ok // [RULE_15]
                                         && xfer_sel == ffe_pkg::SEL_FEAT
                                         |=> fp_enable == $past(fp_enable) && xfer_rdata == $past(xfer_rdata))
        else $error("feature write had an effect");
    a_one_answer: assert property (!(xfer_done && xfer_undef)) // [RULE_11]
        else $error("transfer both accepted and refused");
    a_refuse_clears: assert property (xfer_valid && !sel_ok && !vector_bounce // [RULE_10]
                                      |=> xfer_undef && xfer_rdata == 32'h0000_0000 && !vector_bounce_flag)
        else $error("refusal did not clear answer and flag");
    a_exc_accept: assert property (exc_write_ok |=> xfer_done && !xfer_undef) // [RULE_11]
        else $error("permitted write refused");

    // Main scenarios
    c_feat_read: cover property (feat_read_ok ##1 xfer_done);
    c_enable_on: cover property (exc_write_ok && xfer_wdata[30] ##1 fp_enable);
    c_refused: cover property (xfer_valid && !sel_ok ##1 xfer_undef);
    c_bounce_race: cover property (vector_bounce && undef_other);

endmodule

`default_nettype wire

// File: verilog/ffe_pkg.sv
/*
 * Constants and state type for the floating-point feature and enable register bank.
 * Assumes the core clock and core reset drive every user of this package.
 */
`default_nettype none

package ffe_pkg;

    // ==========================================================================
    // Register select codes on the coprocessor transfer port
    // ==========================================================================
    localparam logic SEL_EXC = 1'b0;  // fp_exception_enable
    localparam logic SEL_FEAT = 1'b1; // media_fp_feature_second

    // ==========================================================================
    // fp_exception_enable layout
    // ==========================================================================
    localparam int ASYNC_BIT = 31;  // async_exception_bit, reads zero
    localparam int ENABLE_BIT = 30; // Global unit enable
    localparam int BOUNCE_BIT = 29; // vector_bounce_flag
    localparam int RSVD_MSB = 28;   // Bits 28..0 read zero
    localparam logic ENABLE_RST = 1'b0;
    localparam logic BOUNCE_RST = 1'b0;

    // ==========================================================================
    // media_fp_feature_second fields, all hard-wired
    // ==========================================================================
    localparam int FMAC_LSB = 28;
    localparam int SHALF_LSB = 24;
    localparam int VEC_LSB = 8;
    localparam int DNAN_LSB = 4;
    localparam int DENORM_LSB = 0;
    localparam logic [3:0] FUSED_MAC_FIELD = 4'h1;
    localparam logic [3:0] SCALAR_HALF_FIELD = 4'h1;
    localparam logic [15:0] VECTOR_FIELDS = 16'h0000; // half, single, integer, load/store
    localparam logic [3:0] DEFAULT_NAN_FIELD = 4'h1;
    localparam logic [3:0] DENORMAL_SUPPORT_FIELD = 4'h1;
    localparam logic [31:0] FEAT_SECOND_VALUE = {FUSED_MAC_FIELD, SCALAR_HALF_FIELD, VECTOR_FIELDS,
                                                 DEFAULT_NAN_FIELD, DENORMAL_SUPPORT_FIELD};
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ==========================================================================
    // Whole state of the register bank
    // ==========================================================================
    typedef struct packed {
        logic enable;       // Global unit enable
        logic bounce;       // Vector bounce flag
        logic [31:0] rdata; // Read answer
        logic done;         // Transfer completed
        logic undef;        // Transfer refused
    } ffe_state_t;

endpackage

`default_nettype wire

// File: verilog/ffe_access_gate.sv
/*
 * Access gate for the register bank: privilege, coprocessor access and
 * non-secure access checks, plus the enable check for feature reads.
 * Assumes all inputs come from core logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module ffe_access_gate (
    // Core state
    input wire logic priv_mode,
    input wire logic nonsecure,
    // coproc_access_ctrl enables
    input wire logic coproc_access_ctrl_fp_coproc_single,
    input wire logic coproc_access_ctrl_fp_coproc_double,
    // nonsecure_access_ctrl enables
    input wire logic nonsecure_access_ctrl_fp_coproc_single,
    input wire logic nonsecure_access_ctrl_fp_coproc_double,
    // Unit enable
    input wire logic unit_enable,
    // Verdicts
    output logic exc_ok,
    output logic feat_ok
);

    // ==========================================================================
    // Decoding
    // ==========================================================================
    // Both coprocessor numbers must agree; one alone grants nothing
    function automatic logic ffe_both_on(input logic single_en, input logic double_en);
        ffe_both_on = single_en & double_en;
    endfunction

    logic ns_ok;

    // Non-secure side needs both access bits set
    assign ns_ok = !nonsecure || ffe_both_on(nonsecure_access_ctrl_fp_coproc_single, nonsecure_access_ctrl_fp_coproc_double); // [RULE_12]
    // Exception register: privilege, coprocessor access and non-secure check
    assign exc_ok = priv_mode && ffe_both_on(coproc_access_ctrl_fp_coproc_single, coproc_access_ctrl_fp_coproc_double) && ns_ok; // [RULE_11]
    // Feature register also needs the unit switched on
    assign feat_ok = exc_ok && unit_enable; // [RULE_14]

endmodule

`default_nettype wire

// File: test/ffe_core_model.sv
/*
 * Model of the host core side: issues coprocessor move transfers one at a time.
 * Assumes the register bank registers its answer on the same edge that takes a request.
 */
`timescale 1ns/1ns
`default_nettype none

module ffe_core_model (
    // Clock
    input wire logic mclk,
    // Transfer request
    output logic xfer_valid,
    output logic xfer_write,
    output logic xfer_sel,
    output logic [31:0] xfer_wdata,
    // Transfer answer
    input wire logic xfer_done,
    input wire logic xfer_undef,
    input wire logic [31:0] xfer_rdata
);
    // ==========================================
    // Idle bus at time zero
    // ==========================================
    initial begin
        xfer_valid = 1'b0;
        xfer_write = 1'b0;
        xfer_sel = 1'b0;
        xfer_wdata = 32'h5a5a_5a5a;
    end

    // One move: write is core-to-coproc, read is coproc-to-core
    task automatic move(input logic wr, input logic sel, input logic [31:0] wd,
                        output logic [1:0] ans, output logic [31:0] rd);
        @(posedge mclk);
        xfer_valid <= 1'b1;
        xfer_write <= wr;
        xfer_sel <= sel;
        xfer_wdata <= wd;
        @(posedge mclk);
        // Released data flips so a stale word never looks valid
        xfer_valid <= 1'b0;
        xfer_wdata <= ~wd;
        #1;
        ans = {xfer_done, xfer_undef};
        rd = xfer_rdata;
    endtask
endmodule

`default_nettype wire

// File: test/tb_ffe_regs.sv
/*
 * Self-checking bench for the feature and enable register bank.
 * Assumes the core model in ffe_core_model.sv drives all transfers.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_ffe_regs;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic xfer_valid, xfer_write, xfer_sel, xfer_done, xfer_undef, fp_enable, vector_bounce_flag;
    logic [31:0] xfer_wdata, xfer_rdata, rd;
    logic [5:0] acc = 6'h2f; // priv, nonsecure, coproc_access_ctrl single/double, nonsecure_access_ctrl single/double
    logic vector_bounce = 1'b0;
    logic undef_other = 1'b0;
    logic [1:0] ans;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    // ==========================================
    // Clock and timeout
    // ==========================================
    always #50 mclk = ~mclk;

    // Ceiling well above the 84 or so cycles the tests need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            print_verdict();
        end
    end

    ffe_regs uut (.mclk(mclk), .rst(rst), .xfer_valid(xfer_valid), .xfer_write(xfer_write),
        .xfer_sel(xfer_sel), .xfer_wdata(xfer_wdata), .priv_mode(acc[5]), .nonsecure(acc[4]),
        .coproc_access_ctrl_fp_coproc_single(acc[3]), .coproc_access_ctrl_fp_coproc_double(acc[2]),
        .nonsecure_access_ctrl_fp_coproc_single(acc[1]), .nonsecure_access_ctrl_fp_coproc_double(acc[0]),
        .vector_bounce(vector_bounce), .undef_other(undef_other), .xfer_done(xfer_done),
        .xfer_undef(xfer_undef), .xfer_rdata(xfer_rdata), .fp_enable(fp_enable),
        .vector_bounce_flag(vector_bounce_flag));

    ffe_core_model core (.mclk(mclk), .xfer_valid(xfer_valid), .xfer_write(xfer_write),
        .xfer_sel(xfer_sel), .xfer_wdata(xfer_wdata), .xfer_done(xfer_done),
        .xfer_undef(xfer_undef), .xfer_rdata(xfer_rdata));

    // ==========================================
    // Compare and helpers
    // ==========================================
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Event pulses one cycle wide, flag settled 1 ns after the taking edge
    task automatic pulse(input logic vb, input logic uo);
        @(posedge mclk);
        vector_bounce <= vb;
        undef_other <= uo;
        @(posedge mclk);
        vector_bounce <= 1'b0;
        undef_other <= 1'b0;
        #1;
    endtask

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic test_reset();
        check_word("enable", 32'h0, {31'h0, fp_enable});
        core.move(1'b0, ffe_pkg::SEL_FEAT, 32'h0, ans, rd);
        check_word("feat answer", 32'h1, {30'h0, ans});
        check_word("feat data", 32'h0, rd);
        $display("reset test done");
    endtask

    task automatic test_enable();
        core.move(1'b1, ffe_pkg::SEL_EXC, 32'hbfff_ffff, ans, rd);
        check_word("enable", 32'h0, {31'h0, fp_enable});
        core.move(1'b0, ffe_pkg::SEL_EXC, 32'h0, ans, rd);
        check_word("exc data", 32'h2000_0000, rd);
        core.move(1'b1, ffe_pkg::SEL_EXC, 32'h5fff_ffff, ans, rd);
        check_word("enable", 32'h1, {31'h0, fp_enable});
        core.move(1'b0, ffe_pkg::SEL_EXC, 32'h0, ans, rd);
        check_word("exc data", 32'h4000_0000, rd);
        $display("enable test done");
    endtask

    task automatic test_feature();
        core.move(1'b0, ffe_pkg::SEL_FEAT, 32'h0, ans, rd);
        check_word("feat data", 32'h1100_0011, rd);
        core.move(1'b1, ffe_pkg::SEL_FEAT, 32'h0, ans, rd);
        check_word("feat write answer", 32'h2, {30'h0, ans});
        core.move(1'b0, ffe_pkg::SEL_FEAT, 32'h0, ans, rd);
        check_word("feat data", 32'h1100_0011, rd);
        $display("feature test done");
    endtask

    task automatic test_events();
        pulse(1'b1, 1'b0);
        check_word("bounce", 32'h1, {31'h0, vector_bounce_flag});
        pulse(1'b0, 1'b1);
        check_word("bounce", 32'h0, {31'h0, vector_bounce_flag});
        pulse(1'b1, 1'b1);
        core.move(1'b0, ffe_pkg::SEL_EXC, 32'h0, ans, rd);
        check_word("exc data", 32'h6000_0000, rd);
        $display("event test done");
    endtask

    // Seven access states: bounce flag set first, so a refusal must clear it
    task automatic test_gate();
        logic [5:0] cases [7];
        logic ok;
        cases = '{6'h2f, 6'h0f, 6'h27, 6'h2b, 6'h3e, 6'h3d, 6'h2c};
        for (int i = 0; i < 7; i++) begin
            @(posedge mclk);
            acc <= cases[i];
            pulse(1'b1, 1'b0);
            ok = cases[i][5] & cases[i][3] & cases[i][2] & (!cases[i][4] | (cases[i][1] & cases[i][0]));
            core.move(1'b0, ffe_pkg::SEL_EXC, 32'h0, ans, rd);
            check_word("gate answer", ok ? 32'h2 : 32'h1, {30'h0, ans});
            check_word("gate data", ok ? 32'h6000_0000 : 32'h0, rd);
            check_word("gate bounce", {31'h0, ok}, {31'h0, vector_bounce_flag});
        end
        $display("gate test done");
    endtask

    // Mid-run reset with the unit on and the bounce flag still set
    task automatic test_mid_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        check_word("enable", 32'h0, {31'h0, fp_enable});
        check_word("bounce", 32'h0, {31'h0, vector_bounce_flag});
        $display("mid reset test done");
    endtask

    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        test_reset();
        test_enable();
        test_feature();
        test_events();
        test_gate();
        test_mid_reset();
        print_verdict();
    end
endmodule

`default_nettype wire
